/* File: rtl/ssu_pkg.sv */
// Purpose: Shared constants of the synchronous serial unit
// Assumes: Byte offsets on a 32-bit AHB-Lite word map
// Notes:   Registers hold 8 bits in the low byte
package ssu_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_BAUD_CONTROL      = 8'h08;
   localparam logic [7:0] OFS_BAUD_DIVISOR_LOW  = 8'h0c;
   localparam logic [7:0] OFS_BAUD_DIVISOR_HIGH = 8'h10;
   localparam logic [7:0] OFS_RECEIVE_DATA      = 8'h14;
   localparam logic [7:0] OFS_TRANSMIT_DATA     = 8'h18;
   localparam logic [7:0] OFS_IRQ_ENABLE        = 8'h1c;
   localparam logic [7:0] OFS_IRQ_FLAGS         = 8'h20;
   // Transmit status and control fields
   localparam int BIT_CLOCK_SOURCE_MASTER = 7;
   localparam int BIT_NINE_BIT_TX_ENABLE  = 6;
   localparam int BIT_TRANSMIT_ENABLE     = 5;
   localparam int BIT_SYNC_MODE           = 4;
   localparam int BIT_BAUD_HIGH_SPEED     = 2;
   localparam int BIT_TX_SHIFT_EMPTY      = 1;
   localparam int BIT_TX_NINTH_BIT        = 0;
   localparam logic [7:0] TX_WRITE_MASK   = 8'hf5;
   // Receive status and control fields
   localparam int BIT_SERIAL_PORT_ENABLE  = 7;
   localparam int BIT_NINE_BIT_RX_ENABLE  = 6;
   localparam int BIT_SINGLE_RX_ENABLE    = 5;
   localparam int BIT_CONTINUOUS_RX       = 4;
   localparam int BIT_OVERRUN_ERROR       = 1;
   localparam int BIT_RX_NINTH_BIT        = 0;
   localparam logic [7:0] RX_WRITE_MASK   = 8'hf0;
   // Baud control fields
   localparam int BIT_RX_IDLE             = 6;
   localparam int BIT_CLOCK_POLARITY      = 4;
   localparam int BIT_BAUD_WIDE_DIVISOR   = 3;
   localparam logic [7:0] BAUD_WRITE_MASK = 8'h18;
   // Interrupt enable and flag fields
   localparam int BIT_RX_IRQ_ENABLE         = 0;
   localparam int BIT_TX_IRQ_ENABLE         = 1;
   localparam int BIT_PERIPHERAL_IRQ_ENABLE = 2;
   localparam int BIT_GLOBAL_IRQ_ENABLE     = 3;
   localparam int BIT_RX_IRQ_FLAG           = 0;
   localparam int BIT_TX_IRQ_FLAG           = 1;
   // Reset values, character lengths and FIFO depth
   localparam logic [7:0] RST_CONTROL     = 8'h00;
   localparam logic [3:0] RST_IRQ_ENABLE  = 4'h0;
   localparam logic [3:0] CHAR_BITS_SHORT = 4'h8;
   localparam logic [3:0] CHAR_BITS_LONG  = 4'h9;
   localparam logic [1:0] RX_FIFO_DEPTH   = 2'h2;
endpackage

/* File: rtl/ssu_serial_unit.sv */
// Purpose: Synchronous serial unit, master and slave, with AHB-Lite registers
// Assumes: Pins arrive asynchronously; sleep_mode stops only the master clock
// Notes:   Zero wait state bus slave, response always OKAY
// Summary of operation
// - Nine-bit receive shifts nine bits per character instead of eight.
// - Receive ninth bit shows bit nine of the oldest unread character.
// - Receive flag sets on a whole character; interrupt if enabled.
// - Receive status shows ninth bit and overrun before data is read.
// - Reading receive data returns the low eight bits of the character.
// - Overrun clears by clearing continuous receive or port enable; in master mode with single receive set, the code also needs a data read.
// - Sync mode, clock source clear, port enabled gives slave operation.
// - Both receive enables clear means transmit; continuous set, or single set in master mode, means receive.
// - Slave transmit as master; second word stays buffered, flag clear.
// - After first character, buffered word moves to shift register; flag sets.
// - Transmit flag with peripheral and transmit enables wakes; global adds interrupt.
// - Slave receive with continuous enable idles only while overrun is set.
// - Single receive enable is ignored in slave mode.
// - Slave keeps receiving in sleep on the external clock.
// - Receive flag with receive enable wakes from sleep; global and peripheral enables add interrupt.
// - Unimplemented register bits read as zero.
// - Slave disables clock driver and shifts one bit per external clock.
// - Data sampled on trailing edge; characters enter a two-deep FIFO.
// - Third character into full FIFO sets overrun; FIFO kept, reception halts.
// - Polarity bit selects idle clock level and the data change edge.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module ssu_serial_unit
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        sleep_mode,
   input  wire logic        clock_pin_in,
   output logic             clock_pin_out,
   output logic             clock_pin_oe,
   input  wire logic        data_pin_in,
   output logic             data_pin_out,
   output logic             data_pin_oe,
   output logic             rx_irq_flag,
   output logic             tx_irq_flag,
   output logic             irq_request,
   output logic             wake_request
);
   logic [7:0]  tx_ctrl_q;
   logic [7:0]  rx_ctrl_q;
   logic [7:0]  baud_ctrl_q;
   logic [7:0]  div_lo_q;
   logic [7:0]  div_hi_q;
   logic [3:0]  irq_en_q;
   logic        dph_wr_q;
   logic [7:0]  dph_addr_q;
   logic [31:0] hrdata_q;
   logic        addr_phase;
   logic        rd_pop;
   logic [7:0]  rd_val;
   logic [7:0]  wdat;
   logic        serial_port_enable;
   logic        sync_on;
   logic        master;
   logic        rx_sel;
   logic        rx_run;
   logic        tx_run;
   logic        clock_polarity_select;
   logic [2:0]  ck_s_q;
   logic [2:0]  dt_s_q;
   logic        ck_f_q;
   logic        dt_f_q;
   logic [15:0] gen_cnt_q;
   logic [15:0] div_val;
   logic        gen_run;
   logic        ck_gen_q;
   logic        ck_now;
   logic        ck_prev_q;
   logic        lead;
   logic        trail;
   logic [8:0]  tx_buf_q;
   logic        tx_full_q;
   logic [8:0]  tsr_q;
   logic        tsr_busy_q;
   logic [3:0]  tx_cnt_q;
   logic        dout_q;
   logic [3:0]  tx_bits;
   logic [3:0]  rx_bits;
   logic [8:0]  rsr_q;
   logic [8:0]  rsr_next;
   logic [3:0]  rx_cnt_q;
   logic [8:0]  fifo_q [0:1];
   logic        wr_ptr_q;
   logic        rd_ptr_q;
   logic [1:0]  fifo_cnt_q;
   logic        overrun_error_flag_q;
   logic        rx_done;
   logic        single_rx_enable_clr;
   logic        overrun_error_flag_clr;
   logic        rx_hit;
   logic        tx_hit;

   assign addr_phase = hsel & htrans[1] & hready;
   assign wdat       = hwdata[7:0];
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = hrdata_q;
   assign rd_pop     = addr_phase & ~hwrite & (haddr[7:0] == ssu_pkg::OFS_RECEIVE_DATA) & (fifo_cnt_q != 2'h0);

   assign serial_port_enable    = rx_ctrl_q[ssu_pkg::BIT_SERIAL_PORT_ENABLE];
   assign clock_polarity_select    = baud_ctrl_q[ssu_pkg::BIT_CLOCK_POLARITY];
   assign sync_on = serial_port_enable & tx_ctrl_q[ssu_pkg::BIT_SYNC_MODE];
   assign master  = sync_on & tx_ctrl_q[ssu_pkg::BIT_CLOCK_SOURCE_MASTER];
   assign rx_sel  = rx_ctrl_q[ssu_pkg::BIT_CONTINUOUS_RX]
                    | (master & rx_ctrl_q[ssu_pkg::BIT_SINGLE_RX_ENABLE]);
   assign rx_run  = sync_on & rx_sel & ~overrun_error_flag_q;
   assign tx_run  = sync_on & ~rx_sel & tx_ctrl_q[ssu_pkg::BIT_TRANSMIT_ENABLE];
   assign tx_bits = tx_ctrl_q[ssu_pkg::BIT_NINE_BIT_TX_ENABLE] ? ssu_pkg::CHAR_BITS_LONG : ssu_pkg::CHAR_BITS_SHORT;
   assign rx_bits = rx_ctrl_q[ssu_pkg::BIT_NINE_BIT_RX_ENABLE] ? ssu_pkg::CHAR_BITS_LONG : ssu_pkg::CHAR_BITS_SHORT;

   // Bus address and data phase tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_wr_q   <= 1'b0;
         dph_addr_q <= 8'h00;
         hrdata_q   <= 32'h0000_0000;
      end
      else
      begin
         dph_wr_q <= addr_phase & hwrite;
         if (addr_phase)
         begin
            dph_addr_q <= haddr[7:0];
         end
         hrdata_q <= (addr_phase & ~hwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
   end

   // Register read multiplexer
   always_comb
   begin
      unique case (haddr[7:0])
         // Status shows ninth bit and overrun
         ssu_pkg::OFS_RX_STATUS_CONTROL:
            rd_val = rx_ctrl_q | {6'h00, overrun_error_flag_q, fifo_q[rd_ptr_q][8]};
         ssu_pkg::OFS_TX_STATUS_CONTROL:
            rd_val = tx_ctrl_q | {6'h00, ~tsr_busy_q, 1'b0};
         ssu_pkg::OFS_BAUD_CONTROL:
            rd_val = baud_ctrl_q | {1'b0, ~rx_run, 6'h00};
         ssu_pkg::OFS_BAUD_DIVISOR_LOW:
            rd_val = div_lo_q;
         ssu_pkg::OFS_BAUD_DIVISOR_HIGH:
            rd_val = div_hi_q;
         ssu_pkg::OFS_RECEIVE_DATA:
            rd_val = fifo_q[rd_ptr_q][7:0];
         ssu_pkg::OFS_IRQ_ENABLE:
            rd_val = {4'h0, irq_en_q};
         ssu_pkg::OFS_IRQ_FLAGS:
            rd_val = {6'h00, tx_irq_flag, rx_irq_flag};
         default:
            rd_val = 8'h00;
      endcase
   end

   // Software control registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_ctrl_q   <= ssu_pkg::RST_CONTROL;
         rx_ctrl_q   <= ssu_pkg::RST_CONTROL;
         baud_ctrl_q <= ssu_pkg::RST_CONTROL;
         div_lo_q    <= ssu_pkg::RST_CONTROL;
         div_hi_q    <= ssu_pkg::RST_CONTROL;
         irq_en_q    <= ssu_pkg::RST_IRQ_ENABLE;
      end
      else
      begin
         if (single_rx_enable_clr)
         begin
            rx_ctrl_q[ssu_pkg::BIT_SINGLE_RX_ENABLE] <= 1'b0;
         end
         if (dph_wr_q)
         begin
            unique case (dph_addr_q)
               ssu_pkg::OFS_TX_STATUS_CONTROL: tx_ctrl_q   <= wdat & ssu_pkg::TX_WRITE_MASK;
               ssu_pkg::OFS_RX_STATUS_CONTROL: rx_ctrl_q   <= wdat & ssu_pkg::RX_WRITE_MASK;
               ssu_pkg::OFS_BAUD_CONTROL:      baud_ctrl_q <= wdat & ssu_pkg::BAUD_WRITE_MASK;
               ssu_pkg::OFS_BAUD_DIVISOR_LOW:  div_lo_q    <= wdat;
               ssu_pkg::OFS_BAUD_DIVISOR_HIGH: div_hi_q    <= wdat;
               ssu_pkg::OFS_IRQ_ENABLE:        irq_en_q    <= wdat[3:0];
               default:                        irq_en_q    <= irq_en_q;
            endcase
         end
      end
   end

   // Pin synchronisers, change taken when stages two and three agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ck_s_q <= 3'h0;
         dt_s_q <= 3'h0;
         ck_f_q <= 1'b0;
         dt_f_q <= 1'b0;
      end
      else
      begin
         ck_s_q <= {ck_s_q[1:0], clock_pin_in};
         dt_s_q <= {dt_s_q[1:0], data_pin_in};
         if (ck_s_q[1] == ck_s_q[2])
         begin
            ck_f_q <= ck_s_q[2];
         end
         if (dt_s_q[1] == dt_s_q[2])
         begin
            dt_f_q <= dt_s_q[2];
         end
      end
   end

   // Master clock generator, halted in sleep
   assign div_val = baud_ctrl_q[ssu_pkg::BIT_BAUD_WIDE_DIVISOR] ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
   assign gen_run = master & ~sleep_mode & ((tx_run & tsr_busy_q) | rx_run);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gen_cnt_q <= 16'h0000;
         ck_gen_q  <= 1'b0;
      end
      else if (!gen_run)
      begin
         gen_cnt_q <= 16'h0000;
         ck_gen_q  <= clock_polarity_select;
      end
      else if (gen_cnt_q == div_val)
      begin
         gen_cnt_q <= 16'h0000;
         ck_gen_q  <= ~ck_gen_q;
      end
      else
      begin
         gen_cnt_q <= gen_cnt_q + 16'h0001;
      end
   end

   assign ck_now = master ? ck_gen_q : ck_f_q;
   assign lead   = (ck_now != ck_prev_q) & (ck_prev_q == clock_polarity_select);
   assign trail  = (ck_now != ck_prev_q) & (ck_now == clock_polarity_select);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ck_prev_q <= 1'b0;
      end
      else
      begin
         ck_prev_q <= ck_now;
      end
   end

   // Transmit buffer and shift register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_buf_q   <= 9'h000;
         tx_full_q  <= 1'b0;
         tsr_q      <= 9'h000;
         tsr_busy_q <= 1'b0;
         tx_cnt_q   <= 4'h0;
         dout_q     <= 1'b0;
      end
      else if (!serial_port_enable)
      begin
         tx_full_q  <= 1'b0;
         tsr_busy_q <= 1'b0;
         tx_cnt_q   <= 4'h0;
      end
      else
      begin
         if (tx_run & ~tsr_busy_q & tx_full_q)
         begin
            tsr_q      <= tx_buf_q;
            tsr_busy_q <= 1'b1;
            tx_cnt_q   <= 4'h0;
            tx_full_q  <= 1'b0;
         end
         else if (!tx_run)
         begin
            tsr_busy_q <= 1'b0;
            tx_cnt_q   <= 4'h0;
         end
         else if (lead & tsr_busy_q & (tx_cnt_q < tx_bits))
         begin
            dout_q   <= tsr_q[0];
            tsr_q    <= {1'b0, tsr_q[8:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
         end
         else if (trail & tsr_busy_q & (tx_cnt_q == tx_bits))
         begin
            tsr_busy_q <= 1'b0;
         end
         if (dph_wr_q & (dph_addr_q == ssu_pkg::OFS_TRANSMIT_DATA))
         begin
            tx_buf_q  <= {tx_ctrl_q[ssu_pkg::BIT_TX_NINTH_BIT], wdat};
            tx_full_q <= 1'b1;
         end
      end
   end

   assign rsr_next = rx_ctrl_q[ssu_pkg::BIT_NINE_BIT_RX_ENABLE] ? {dt_f_q, rsr_q[8:1]}
                                                              : {1'b0, dt_f_q, rsr_q[7:1]};
   assign rx_done  = rx_run & trail & (rx_cnt_q == rx_bits - 4'h1);
   assign single_rx_enable_clr = rx_done & master;
   assign overrun_error_flag_clr = ~rx_ctrl_q[ssu_pkg::BIT_CONTINUOUS_RX]
                     & (~(master & rx_ctrl_q[ssu_pkg::BIT_SINGLE_RX_ENABLE]) | rd_pop);

   // Receive shift register, FIFO and overrun
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rsr_q      <= 9'h000;
         rx_cnt_q   <= 4'h0;
         fifo_q[0]  <= 9'h000;
         fifo_q[1]  <= 9'h000;
         wr_ptr_q   <= 1'b0;
         rd_ptr_q   <= 1'b0;
         fifo_cnt_q <= 2'h0;
         overrun_error_flag_q     <= 1'b0;
      end
      else if (!serial_port_enable)
      begin
         rx_cnt_q   <= 4'h0;
         wr_ptr_q   <= 1'b0;
         rd_ptr_q   <= 1'b0;
         fifo_cnt_q <= 2'h0;
         overrun_error_flag_q     <= 1'b0;
      end
      else
      begin
         if (!rx_run)
         begin
            rx_cnt_q <= 4'h0;
         end
         else if (rx_done)
         begin
            rx_cnt_q <= 4'h0;
         end
         else if (trail)
         begin
            rsr_q    <= rsr_next;
            rx_cnt_q <= rx_cnt_q + 4'h1;
         end
         if (rx_done & (fifo_cnt_q == ssu_pkg::RX_FIFO_DEPTH))
         begin
            overrun_error_flag_q <= 1'b1;
         end
         else if (overrun_error_flag_clr)
         begin
            overrun_error_flag_q <= 1'b0;
         end
         if (rx_done & (fifo_cnt_q != ssu_pkg::RX_FIFO_DEPTH))
         begin
            fifo_q[wr_ptr_q] <= rsr_next;
            wr_ptr_q         <= ~wr_ptr_q;
         end
         if (rd_pop)
         begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         unique case ({rx_done & (fifo_cnt_q != ssu_pkg::RX_FIFO_DEPTH), rd_pop})
            2'b10:   fifo_cnt_q <= fifo_cnt_q + 2'h1;
            2'b01:   fifo_cnt_q <= fifo_cnt_q - 2'h1;
            default: fifo_cnt_q <= fifo_cnt_q;
         endcase
      end
   end

   // Flags from FIFO and buffer state
   assign rx_irq_flag = (fifo_cnt_q != 2'h0);
   assign tx_irq_flag = ~tx_full_q;
   assign rx_hit = rx_irq_flag & irq_en_q[ssu_pkg::BIT_RX_IRQ_ENABLE];
   assign tx_hit = tx_irq_flag & irq_en_q[ssu_pkg::BIT_TX_IRQ_ENABLE]
                   & irq_en_q[ssu_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
   assign wake_request = sleep_mode & (rx_hit | tx_hit);
   assign irq_request  = irq_en_q[ssu_pkg::BIT_GLOBAL_IRQ_ENABLE]
                         & irq_en_q[ssu_pkg::BIT_PERIPHERAL_IRQ_ENABLE] & (rx_hit | tx_hit);

   assign clock_pin_oe  = master & (rx_sel | tx_ctrl_q[ssu_pkg::BIT_TRANSMIT_ENABLE]);
   assign clock_pin_out = ck_gen_q;
   assign data_pin_oe   = tx_run;
   assign data_pin_out  = dout_q;

endmodule // ssu_serial_unit

/* File: dv/ssu_serial_unit_asserts.sv */
// Purpose: Port checks for the serial unit
// Assumes: Bound to ssu_serial_unit
// Notes:   Ages count hclk cycles since events
`timescale 1ns/10ps
module ssu_serial_unit_asserts
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        sleep_mode,
   input wire logic        clock_pin_in,
   input wire logic        clock_pin_out,
   input wire logic        data_pin_out,
   input wire logic        rx_irq_flag,
   input wire logic        tx_irq_flag,
   input wire logic        irq_request,
   input wire logic        wake_request
);
   logic [3:0] clk_age_q;
   logic [3:0] bus_age_q;
   logic       ck_in_q;
   logic       ck_out_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_age_q <= 4'h0;
         bus_age_q <= 4'h0;
         ck_in_q   <= 1'b0;
         ck_out_q  <= 1'b0;
      end
      else
      begin
         ck_in_q  <= clock_pin_in;
         ck_out_q <= clock_pin_out;
         if (clock_pin_in != ck_in_q || clock_pin_out != ck_out_q)
            clk_age_q <= 4'h0;
         else if (clk_age_q != 4'hf)
            clk_age_q <= clk_age_q + 4'h1;
         if (hsel && htrans[1] && hready)
            bus_age_q <= 4'h0;
         else if (bus_age_q != 4'hf)
            bus_age_q <= bus_age_q + 4'h1;
      end
   end
   chk_ready_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   chk_read_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_read_one_cycle: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   chk_rx_flag_cause: assert property ($rose(rx_irq_flag) |-> clk_age_q <= 4'h8)
      else $error("receive flag rose without clock");
   chk_rx_flag_pop: assert property ($fell(rx_irq_flag) |-> bus_age_q <= 4'h3)
      else $error("receive flag fell without access");
   chk_tx_flag_write: assert property ($fell(tx_irq_flag) |-> bus_age_q <= 4'h3)
      else $error("transmit flag fell without write");
   chk_tx_flag_cause: assert property ($rose(tx_irq_flag) |-> clk_age_q <= 4'h8 || bus_age_q <= 4'h3)
      else $error("transmit flag rose without cause");
   chk_data_hold: assert property ($changed(data_pin_out) |-> clk_age_q <= 4'h8 || bus_age_q <= 4'h3)
      else $error("data pin moved between clock edges");
   chk_wake_cause: assert property (wake_request |-> sleep_mode && (rx_irq_flag || tx_irq_flag))
      else $error("wake without sleep or flag");
   chk_irq_cause: assert property (irq_request |-> rx_irq_flag || tx_irq_flag)
      else $error("interrupt without flag");
   cover property ($rose(rx_irq_flag));
   cover property ($fell(tx_irq_flag));
   cover property (wake_request);
   cover property (irq_request);
endmodule // ssu_serial_unit_asserts

/* File: dv/ssu_link_partner.sv */
// Purpose: External synchronous master on the link
// Assumes: Device runs as synchronous slave
// Notes:   Released data line shows inverted last value
`timescale 1ns/10ps
module ssu_link_partner
(
   input  wire logic line_data,
   output logic      clk_line,
   output logic      dat_line
);
   initial
   begin
      clk_line = 1'b0;
      dat_line = 1'b1;
   end
   // Clock and data parked off the hclk edge
   task automatic park(input logic ck, input logic dt);
      #13;
      clk_line = ck;
      dat_line = dt;
   endtask
   // idle level, data on leading edge
   task automatic xfer(input logic pol, input logic [8:0] tx, input int n, input logic drv,
                       output logic [8:0] rx);
      rx = 9'h0;
      clk_line = pol;
      #13;
      for (int i = 0; i < n; i++)
      begin
         dat_line = drv ? tx[i] : ~dat_line;
         #100 clk_line = ~pol;
         #200 clk_line = pol;
         #90 rx[i] = line_data;
         #10;
      end
      #200 dat_line = ~dat_line;
   endtask
endmodule // ssu_link_partner

/* File: dv/testbench.sv */
// Purpose: Self-checking bench of the serial unit
// Assumes: Partner acts as external link master
// Notes:   AHB-Lite single word transfers
`timescale 1ns/10ps
module testbench;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        sleep_mode;
   logic        clock_pin_out;
   logic        clock_pin_oe;
   logic        data_pin_out;
   logic        data_pin_oe;
   logic        rx_irq_flag;
   logic        tx_irq_flag;
   logic        irq_request;
   logic        wake_request;
   logic        p_clk;
   logic        p_dat;
   logic        ck_line;
   logic        dt_line;
   logic [7:0]  rv;
   int          err_count;
   int          cmp_count;
   assign ck_line = clock_pin_oe ? clock_pin_out : p_clk;
   assign dt_line = data_pin_oe ? data_pin_out : p_dat;
   ssu_serial_unit ssu_serial_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep_mode(sleep_mode),
      .clock_pin_in(ck_line), .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
      .data_pin_in(dt_line), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
      .rx_irq_flag(rx_irq_flag), .tx_irq_flag(tx_irq_flag), .irq_request(irq_request),
      .wake_request(wake_request));
   ssu_link_partner ssu_link_partner_i (.line_data(dt_line), .clk_line(p_clk), .dat_line(p_dat));
   initial
      hclk = 1'b0;
   always #25 hclk = ~hclk;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      r = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, rv);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      bus(a, 1'b0, 8'h00, r);
   endtask
   task automatic t_regs;
      logic [7:0] r;
      rd(ssu_pkg::OFS_RX_STATUS_CONTROL, r);
      chk(r, ssu_pkg::RST_CONTROL);
      wr(ssu_pkg::OFS_BAUD_CONTROL, 8'hff);
      rd(ssu_pkg::OFS_BAUD_CONTROL, r);
      chk(r & 8'hbf, ssu_pkg::BAUD_WRITE_MASK);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h0f);
      rd(ssu_pkg::OFS_RX_STATUS_CONTROL, r);
      chk(r, 8'h00);
      wr(ssu_pkg::OFS_BAUD_DIVISOR_LOW, 8'ha5);
      wr(ssu_pkg::OFS_BAUD_DIVISOR_HIGH, 8'h5a);
      rd(ssu_pkg::OFS_BAUD_DIVISOR_LOW, r);
      chk(r, 8'ha5);
      rd(ssu_pkg::OFS_BAUD_DIVISOR_HIGH, r);
      chk(r, 8'h5a);
      rd(ssu_pkg::OFS_TRANSMIT_DATA, r);
      chk(r, 8'h00);
      rd(8'h24, r);
      chk(r, 8'h00);
      $display("test registers done");
   endtask
   task automatic t_slave_rx(input logic pol, input logic nine, input logic slp, input logic [8:0] d);
      logic [7:0] r;
      logic [8:0] x;
      ssu_link_partner_i.park(pol, 1'b1);
      wr(ssu_pkg::OFS_BAUD_CONTROL, {3'h0, pol, 4'h0});
      wr(ssu_pkg::OFS_TX_STATUS_CONTROL, 8'h10);
      wr(ssu_pkg::OFS_IRQ_ENABLE, slp ? 8'h01 : 8'h0d);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, {1'b1, nine, 2'b11, 4'h0});
      sleep_mode <= slp;
      rd(ssu_pkg::OFS_BAUD_CONTROL, r);
      chk(r & 8'h40, 8'h00);
      chk({7'h0, data_pin_oe}, 8'h00);
      chk({7'h0, clock_pin_oe}, 8'h00);
      ssu_link_partner_i.xfer(pol, d, nine ? 9 : 8, 1'b1, x);
      for (int i = 0; i < 40 && rx_irq_flag !== 1'b1; i++)
         @(posedge hclk);
      chk({7'h0, rx_irq_flag}, 8'h01);
      chk({7'h0, wake_request}, {7'h0, slp});
      chk({7'h0, irq_request}, {7'h0, !slp});
      @(posedge hclk);
      sleep_mode <= 1'b0;
      rd(ssu_pkg::OFS_RX_STATUS_CONTROL, r);
      chk(r & 8'h03, {7'h0, nine & d[8]});
      rd(ssu_pkg::OFS_RECEIVE_DATA, r);
      chk(r, d[7:0]);
      @(posedge hclk);
      chk({7'h0, rx_irq_flag}, 8'h00);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h00);
      $display("test slave receive done");
   endtask
   task automatic t_overrun;
      logic [7:0] r;
      logic [8:0] x;
      wr(ssu_pkg::OFS_BAUD_CONTROL, 8'h00);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h90);
      for (int i = 0; i < 4; i++)
         ssu_link_partner_i.xfer(1'b0, {1'b0, 8'h31 + 8'(i)}, 8, 1'b1, x);
      rd(ssu_pkg::OFS_RX_STATUS_CONTROL, r);
      chk(r & 8'h02, 8'h02);
      rd(ssu_pkg::OFS_RECEIVE_DATA, r);
      chk(r, 8'h31);
      rd(ssu_pkg::OFS_RECEIVE_DATA, r);
      chk(r, 8'h32);
      @(posedge hclk);
      chk({7'h0, rx_irq_flag}, 8'h00);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h80);
      rd(ssu_pkg::OFS_RX_STATUS_CONTROL, r);
      chk(r, 8'h80);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h00);
      $display("test overrun done");
   endtask
   task automatic t_slave_tx;
      logic [8:0] x;
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h80);
      wr(ssu_pkg::OFS_IRQ_ENABLE, 8'h06);
      wr(ssu_pkg::OFS_TX_STATUS_CONTROL, 8'h71);
      @(posedge hclk);
      chk({7'h0, data_pin_oe}, 8'h01);
      chk({7'h0, clock_pin_oe}, 8'h00);
      wr(ssu_pkg::OFS_TRANSMIT_DATA, 8'h5a);
      wr(ssu_pkg::OFS_TX_STATUS_CONTROL, 8'h70);
      wr(ssu_pkg::OFS_TRANSMIT_DATA, 8'hc3);
      sleep_mode <= 1'b1;
      @(posedge hclk);
      chk({7'h0, tx_irq_flag}, 8'h00);
      ssu_link_partner_i.xfer(1'b0, 9'h0, 9, 1'b0, x);
      chk(x[7:0], 8'h5a);
      chk({7'h0, x[8]}, 8'h01);
      @(posedge hclk);
      chk({7'h0, tx_irq_flag}, 8'h01);
      chk({7'h0, wake_request}, 8'h01);
      chk({7'h0, irq_request}, 8'h00);
      wr(ssu_pkg::OFS_IRQ_ENABLE, 8'h0e);
      @(posedge hclk);
      chk({7'h0, irq_request}, 8'h01);
      ssu_link_partner_i.xfer(1'b0, 9'h0, 9, 1'b0, x);
      chk(x[7:0], 8'hc3);
      chk({7'h0, x[8]}, 8'h00);
      @(posedge hclk);
      sleep_mode <= 1'b0;
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h00);
      $display("test slave transmit done");
   endtask
   task automatic t_master_rx;
      logic [7:0] r;
      ssu_link_partner_i.park(1'b0, 1'b1);
      wr(ssu_pkg::OFS_TX_STATUS_CONTROL, 8'h90);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'ha0);
      repeat (2700) @(posedge hclk);
      chk({7'h0, rx_irq_flag}, 8'h01);
      rd(ssu_pkg::OFS_RX_STATUS_CONTROL, r);
      chk(r & 8'h20, 8'h00);
      rd(ssu_pkg::OFS_RECEIVE_DATA, r);
      chk(r, 8'hff);
      wr(ssu_pkg::OFS_RX_STATUS_CONTROL, 8'h00);
      $display("test master rx done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      err_count = 0;
      cmp_count = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      sleep_mode = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_slave_rx(1'b0, 1'b0, 1'b0, 9'h0b4);
      t_slave_rx(1'b1, 1'b1, 1'b0, 9'h1c3);
      t_slave_rx(1'b0, 1'b1, 1'b1, 9'h15a);
      t_overrun;
      t_slave_tx;
      t_master_rx;
      end_of_test;
   end
   initial
   begin
      #2000000;
      err_count++;
      $display("watchdog expired");
      end_of_test;
   end
endmodule // testbench
bind ssu_serial_unit ssu_serial_unit_asserts ssu_serial_unit_asserts_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .sleep_mode(sleep_mode), .clock_pin_in(clock_pin_in),
   .clock_pin_out(clock_pin_out), .data_pin_out(data_pin_out), .rx_irq_flag(rx_irq_flag),
   .tx_irq_flag(tx_irq_flag), .irq_request(irq_request), .wake_request(wake_request));
